/* File: hw/rmc_map.vh */
`ifndef RMC_MAP_VH
`define RMC_MAP_VH

// ---------------------------------------------------------------
// clock rates and derived divider counts
// ---------------------------------------------------------------
`define RMC_SYS_HZ 64'd200000000
`define RMC_CPU_CLK_HZ 64'd5000000
`define RMC_TMR_CLK_MILLIHZ 64'd39062500
`define RMC_CPU_HALF (`RMC_SYS_HZ / (64'd2 * `RMC_CPU_CLK_HZ))
`define RMC_TMR_HALF ((64'd1000 * `RMC_SYS_HZ) / (64'd2 * `RMC_TMR_CLK_MILLIHZ))

// ---------------------------------------------------------------
// register offsets on the low address byte
// ---------------------------------------------------------------
`define RMC_OFS_GATE_CNT0 6'h00
`define RMC_OFS_GATE_CNT3 6'h03
`define RMC_OFS_EVT_CNT0 6'h04
`define RMC_OFS_EVT_CNT3 6'h07
`define RMC_OFS_STATUS 6'h08
`define RMC_OFS_FUNC 6'h09
`define RMC_OFS_GTIME_LO 6'h0a
`define RMC_OFS_GTIME_HI 6'h0b
`define RMC_OFS_CTRL 6'h0c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define RMC_ST_DONE 0
`define RMC_ST_EXT_PRESENT 1
`define RMC_ST_EXT_IN_USE 2
`define RMC_ST_GATE 3
`define RMC_CTRL_ARM 0
`define RMC_CTRL_SF21 1
`define RMC_FCODE_GATE_BIT 3

// ---------------------------------------------------------------
// measurement functions and their five-line codes
// ---------------------------------------------------------------
`define RMC_FN_FIRST_CHANNEL_FREQUENCY 4'h0
`define RMC_FN_SECOND_CHANNEL_FREQUENCY 4'h1
`define RMC_FN_PERIOD_A 4'h2
`define RMC_FN_TI_AB 4'h3
`define RMC_FN_TOTAL_A_BY_B 4'h4
`define RMC_FN_RATIO_AB 4'h5
`define RMC_FN_CHECK 4'h6
`define RMC_FN_TOTAL_A 4'h7
`define RMC_FN_TIME 4'h8
`define RMC_FC_FIRST_CHANNEL_FREQUENCY 5'h0d
`define RMC_FC_SECOND_CHANNEL_FREQUENCY 5'h09
`define RMC_FC_PERIOD_A 5'h0c
`define RMC_FC_TI_AB 5'h19
`define RMC_FC_TOTAL_A_BY_B 5'h17
`define RMC_FC_RATIO_AB 5'h1d
`define RMC_FC_CHECK 5'h05
`define RMC_FC_TOTAL_A 5'h0d
`define RMC_FC_TIME 5'h0d

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RMC_RST_FUNC 4'h0
`define RMC_RST_GTIME 16'h0100
`define RMC_RST_DELAY 16'h0040

`endif

/* File: hw/rmc_sync.v */
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for a bundle of pin levels
module rmc_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // levels
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);

   reg [WIDTH-1:0] meta_reg;

   // first stage feeds only the second
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= {WIDTH{1'b0}};
         q <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule // rmc_sync

`default_nettype wire

/* File: hw/rmc_top.v */
// Function
// R1 - gate opens and closes on measured-signal edges, never on the count clock
// R2 - each gate spans a whole number of measured-signal cycles
// R3 - gate duration is the count of reference pulses while gate is open
// R4 - host configures function and gate time before every measurement
// R5 - measured signals go straight into the input counter logic
// R6 - both channels' differential outputs feed the measurement in every function; here channel B feeds it only in second-channel frequency without SF21
// R7 - control counter raises an interrupt when each measurement finishes
// R8 - registers addressed by latched address together with counter chip select
// R9 - results returned over the multiplexed bus during the data phase
// R10 - accept internal and external standards; external only with adequate level
// R11 - host polls the external-reference presence flag as a digital input
// R12 - presence high and select line low switches the timebase to external
// R13 - 10 MHz output from the active standard to the standard output connector
// R14 - 10 MHz reference from internal standard sent to the control counter
// R15 - control counter makes a 5 MHz processor clock
// R16 - control counter makes a 39.0625 kHz processor timer clock
// R17 - five function-code lines encode the function, static without input signals
// R18 - in self-check, function-code line three follows the gate indicator
// R19 - second-channel frequency is first-channel frequency with delay under SF21
// R20 - gate indicator driven from the measurement block showing gate open
// R21 - host holds low address during strobe high, latched on its fall
// R22 - host decodes chip select, valid only in the data phase
// R23 - completed counts held in result registers until read after interrupt
// R24 - internal standard used when select line high or no external reference
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.vh"

module rmc_top #(
   parameter CNT_W = 32,
   parameter DELAY_CYCLES = `RMC_RST_DELAY
) (
   // clock and reset
   input wire SYS_CLK,
   input wire RST,
   // channel differential pairs
   input wire CHA_P,
   input wire CHA_N,
   input wire CHB_P,
   input wire CHB_N,
   // frequency standards and reference select
   input wire INT_REF,
   input wire EXT_REF,
   input wire EXT_LEVEL,
   input wire REF_SELECT_N,
   // multiplexed processor bus
   input wire ADDR_STROBE,
   input wire DATA_STROBE,
   input wire READ_NOT_WRITE,
   input wire COUNTER_CHIP_SELECT_N,
   input wire [7:0] BUS_IN,
   output reg [7:0] BUS_OUT,
   output reg BUS_OE,
   // interrupt and status pins
   output reg IRQ_N,
   output reg EXT_PRESENT,
   output reg GATE_LED,
   output reg [4:0] FUNCTION_CODE,
   // clocks made for the rest of the system
   output reg STD_OUT_10M,
   output reg REF_OUT_10M,
   output reg CPU_CLK,
   output reg TIMER_CLK
);

   // ---------------------------------------------------------------
   // synchronised pin levels
   // ---------------------------------------------------------------
   localparam [63:0] CPU_HALF = `RMC_CPU_HALF;
   localparam [63:0] TMR_HALF = `RMC_TMR_HALF;
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_DELAY = 5'h02;
   localparam [4:0] S_ARMED = 5'h04;
   localparam [4:0] S_OPEN = 5'h08;
   localparam [4:0] S_DONE = 5'h10;

   wire cha_p_s, cha_n_s, chb_p_s, chb_n_s, int_ref_s, ext_ref_s, ext_lvl_s;
   wire ref_sel_n_s, as_s, ds_s, rnw_s, cs_n_s;
   wire [7:0] bus_s;

   rmc_sync #(.WIDTH(20)) u_sync (
      .clk(SYS_CLK),
      .rst(RST),
      .d({BUS_IN, COUNTER_CHIP_SELECT_N, READ_NOT_WRITE, DATA_STROBE, ADDR_STROBE,
          REF_SELECT_N, EXT_LEVEL, EXT_REF, INT_REF, CHB_N, CHB_P, CHA_N, CHA_P}),
      .q({bus_s, cs_n_s, rnw_s, ds_s, as_s, ref_sel_n_s, ext_lvl_s, ext_ref_s,
          int_ref_s, chb_n_s, chb_p_s, cha_n_s, cha_p_s})
   );

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg cha_reg, chb_reg, cha_d_reg, meas_d_reg, ref_d_reg, as_d_reg, ds_d_reg;
   reg [5:0] addr_reg;
   reg [3:0] func_reg;
   reg [15:0] gtime_reg;
   reg sf21_reg, arm_reg, done_reg;
   reg [4:0] state_reg;
   reg [15:0] delay_reg;
   reg [CNT_W-1:0] ref_cnt_reg, evt_cnt_reg, gate_res_reg, evt_res_reg;
   reg [11:0] cpu_div_reg, tmr_div_reg;
   reg [7:0] rd_data;
   reg [4:0] fcode_next;

   wire use_ext = ext_lvl_s & ~ref_sel_n_s;    // R10 R12 R24
   wire ref_lvl = use_ext ? ext_ref_s : int_ref_s;
   wire ref_rise = ref_lvl & ~ref_d_reg;
   wire second_channel_frequency = (func_reg == `RMC_FN_SECOND_CHANNEL_FREQUENCY);
   wire meas_lvl = (second_channel_frequency & ~sf21_reg) ? chb_reg : cha_reg;   // R5 R19
   wire meas_rise = meas_lvl & ~meas_d_reg;
   wire cha_rise = cha_reg & ~cha_d_reg;
   wire cs_data = ~cs_n_s & ds_s;              // R8 R22
   wire ds_fall = ds_d_reg & ~ds_s;
   wire wr_take = ~cs_n_s & ~rnw_s & ds_fall;
   wire status_read = ~cs_n_s & rnw_s & ds_fall & (addr_reg == `RMC_OFS_STATUS);
   wire min_reached = (ref_cnt_reg[CNT_W-1:8] >= {{(CNT_W-24){1'b0}}, gtime_reg});
   wire fin = (state_reg == S_OPEN) & meas_rise & min_reached;
   wire gate_open = (state_reg == S_OPEN) & ~fin;   // lamp drops with the interrupt

   // ---------------------------------------------------------------
   // differential receivers
   // ---------------------------------------------------------------
   // a pair whose legs agree is mid-transition, so the last level holds
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cha_reg <= 1'b0;
         chb_reg <= 1'b0;
      end else begin
         if (cha_p_s != cha_n_s) cha_reg <= cha_p_s;   // R6
         if (chb_p_s != chb_n_s) chb_reg <= chb_p_s;   // R6
      end
   end

   // edge history
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cha_d_reg <= 1'b0;
         meas_d_reg <= 1'b0;
         ref_d_reg <= 1'b0;
         as_d_reg <= 1'b0;
         ds_d_reg <= 1'b0;
      end else begin
         cha_d_reg <= cha_reg;
         meas_d_reg <= meas_lvl;
         ref_d_reg <= ref_lvl;
         as_d_reg <= as_s;
         ds_d_reg <= ds_s;
      end
   end

   // ---------------------------------------------------------------
   // address latch and configuration writes
   // ---------------------------------------------------------------
   // low address byte captured as the address strobe falls
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         addr_reg <= 6'h00;
      end else if (as_d_reg & ~as_s) begin
         addr_reg <= bus_s[5:0];                 // R8
      end
   end

   // writes land at the end of the data phase, when bus data has settled
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         func_reg <= `RMC_RST_FUNC;
         gtime_reg <= `RMC_RST_GTIME;
         sf21_reg <= 1'b0;
         arm_reg <= 1'b0;
      end else begin
         arm_reg <= 1'b0;
         if (wr_take) begin
            case (addr_reg)
               `RMC_OFS_FUNC: func_reg <= bus_s[3:0];
               `RMC_OFS_GTIME_LO: gtime_reg[7:0] <= bus_s;
               `RMC_OFS_GTIME_HI: gtime_reg[15:8] <= bus_s;
               `RMC_OFS_CTRL: begin
                  sf21_reg <= bus_s[`RMC_CTRL_SF21];
                  arm_reg <= bus_s[`RMC_CTRL_ARM];
               end
               default: arm_reg <= 1'b0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // gate sequencer
   // ---------------------------------------------------------------
   // an arm is ignored while the done flag is set, until the status register is read
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state_reg <= S_IDLE;
         delay_reg <= 16'h0000;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (arm_reg & ~done_reg) begin   // R23
                  delay_reg <= DELAY_CYCLES;
                  state_reg <= (second_channel_frequency & sf21_reg) ? S_DELAY : S_ARMED;   // R19
               end
            end
            S_DELAY: begin
               delay_reg <= delay_reg - 16'h0001;
               if (delay_reg == 16'h0001) state_reg <= S_ARMED;   // R19
            end
            S_ARMED: begin
               if (meas_rise) state_reg <= S_OPEN;   // R1
            end
            S_OPEN: begin
               if (fin) state_reg <= S_DONE;         // R1 R2
            end
            S_DONE: state_reg <= S_IDLE;
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // counters and result registers
   // ---------------------------------------------------------------
   // the opening edge is no event but the closing one is, so n cycles count n
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ref_cnt_reg <= {CNT_W{1'b0}};
         evt_cnt_reg <= {CNT_W{1'b0}};
         gate_res_reg <= {CNT_W{1'b0}};
         evt_res_reg <= {CNT_W{1'b0}};
      end else begin
         if (state_reg == S_ARMED) begin
            ref_cnt_reg <= {CNT_W{1'b0}};
            evt_cnt_reg <= {CNT_W{1'b0}};
         end else if (state_reg == S_OPEN & ~fin) begin
            if (ref_rise) ref_cnt_reg <= ref_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};   // R3
            if (cha_rise) evt_cnt_reg <= evt_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         if (fin) begin
            gate_res_reg <= ref_cnt_reg;         // R3 R23
            evt_res_reg <= evt_cnt_reg + {{(CNT_W-1){1'b0}}, cha_rise};   // R2 R23
         end
      end
   end

   // done flag: a finish in the cycle of a status read wins
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= fin | (done_reg & ~status_read);   // R7
      end
   end

   // ---------------------------------------------------------------
   // read path on the multiplexed bus
   // ---------------------------------------------------------------
   always @* begin
      rd_data = 8'h00;
      case (addr_reg)
         6'h00: rd_data = gate_res_reg[7:0];
         6'h01: rd_data = gate_res_reg[15:8];
         6'h02: rd_data = gate_res_reg[23:16];
         `RMC_OFS_GATE_CNT3: rd_data = gate_res_reg[31:24];
         `RMC_OFS_EVT_CNT0: rd_data = evt_res_reg[7:0];
         6'h05: rd_data = evt_res_reg[15:8];
         6'h06: rd_data = evt_res_reg[23:16];
         `RMC_OFS_EVT_CNT3: rd_data = evt_res_reg[31:24];
         `RMC_OFS_STATUS: begin
            rd_data[`RMC_ST_DONE] = done_reg;
            rd_data[`RMC_ST_EXT_PRESENT] = ext_lvl_s;
            rd_data[`RMC_ST_EXT_IN_USE] = use_ext;
            rd_data[`RMC_ST_GATE] = gate_open;
         end
         `RMC_OFS_FUNC: rd_data = {4'h0, func_reg};
         `RMC_OFS_GTIME_LO: rd_data = gtime_reg[7:0];
         `RMC_OFS_GTIME_HI: rd_data = gtime_reg[15:8];
         `RMC_OFS_CTRL: rd_data = {6'h00, sf21_reg, 1'b0};
         default: rd_data = 8'h00;
      endcase
   end

   // drive only inside a selected read data phase
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         BUS_OUT <= 8'h00;
         BUS_OE <= 1'b0;
      end else begin
         BUS_OE <= cs_data & rnw_s;              // R9
         BUS_OUT <= rd_data;                     // R9
      end
   end

   // ---------------------------------------------------------------
   // function code, indicator and flags
   // ---------------------------------------------------------------
   // codes depend on configuration only, except line three following the gate in self-check, so they sit still with no input
   always @* begin
      case (func_reg)
         `RMC_FN_FIRST_CHANNEL_FREQUENCY: fcode_next = `RMC_FC_FIRST_CHANNEL_FREQUENCY;
         `RMC_FN_SECOND_CHANNEL_FREQUENCY: fcode_next = `RMC_FC_SECOND_CHANNEL_FREQUENCY;
         `RMC_FN_PERIOD_A: fcode_next = `RMC_FC_PERIOD_A;
         `RMC_FN_TI_AB: fcode_next = `RMC_FC_TI_AB;
         `RMC_FN_TOTAL_A_BY_B: fcode_next = `RMC_FC_TOTAL_A_BY_B;
         `RMC_FN_RATIO_AB: fcode_next = `RMC_FC_RATIO_AB;
         `RMC_FN_CHECK: fcode_next = `RMC_FC_CHECK;
         `RMC_FN_TOTAL_A: fcode_next = `RMC_FC_TOTAL_A;
         `RMC_FN_TIME: fcode_next = `RMC_FC_TIME;
         default: fcode_next = `RMC_FC_FIRST_CHANNEL_FREQUENCY;
      endcase
      if (func_reg == `RMC_FN_CHECK)
         fcode_next[`RMC_FCODE_GATE_BIT] = gate_open;   // R18
   end

   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         FUNCTION_CODE <= `RMC_FC_FIRST_CHANNEL_FREQUENCY;
         GATE_LED <= 1'b0;
         IRQ_N <= 1'b1;
         EXT_PRESENT <= 1'b0;
      end else begin
         FUNCTION_CODE <= fcode_next;            // R17
         GATE_LED <= gate_open;                  // R20
         IRQ_N <= ~(done_reg | fin);             // R7
         EXT_PRESENT <= ext_lvl_s;               // R11
      end
   end

   // ---------------------------------------------------------------
   // reference outputs and system clocks
   // ---------------------------------------------------------------
   // standards are 10 MHz, so a resampled copy suffices; edge jitter is one
   // system period, the price of keeping a single clock domain
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         STD_OUT_10M <= 1'b0;
         REF_OUT_10M <= 1'b0;
      end else begin
         STD_OUT_10M <= ref_lvl;                 // R13
         REF_OUT_10M <= int_ref_s;               // R14
      end
   end

   // dividers from the system clock
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cpu_div_reg <= 12'h000;
         tmr_div_reg <= 12'h000;
         CPU_CLK <= 1'b0;
         TIMER_CLK <= 1'b0;
      end else begin
         if (cpu_div_reg == CPU_HALF[11:0] - 12'h001) begin
            cpu_div_reg <= 12'h000;
            CPU_CLK <= ~CPU_CLK;                 // R15
         end else begin
            cpu_div_reg <= cpu_div_reg + 12'h001;
         end
         if (tmr_div_reg == TMR_HALF[11:0] - 12'h001) begin
            tmr_div_reg <= 12'h000;
            TIMER_CLK <= ~TIMER_CLK;             // R16
         end else begin
            tmr_div_reg <= tmr_div_reg + 12'h001;
         end
      end
   end

endmodule // rmc_top

`default_nettype wire

/* File: verification/rmc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// port checks of the measurement core
// --------------------------------------------
module rmc_properties (
   // clock and reset
   input wire SYS_CLK,
   input wire RST,
   // inputs watched
   input wire CHA_P,
   input wire CHB_P,
   input wire EXT_LEVEL,
   input wire DATA_STROBE,
   input wire READ_NOT_WRITE,
   input wire COUNTER_CHIP_SELECT_N,
   // outputs watched
   input wire BUS_OE,
   input wire IRQ_N,
   input wire EXT_PRESENT,
   input wire GATE_LED,
   input wire [4:0] FUNCTION_CODE,
   input wire CPU_CLK,
   input wire TIMER_CLK
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   logic [11:0] cpu_cnt_reg;
   logic [11:0] tmr_cnt_reg;
   logic cpu_seen_reg;
   logic tmr_seen_reg;
   // cycles since each made clock last moved; the first move after reset is untimed
   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cpu_cnt_reg <= 12'h000;
         tmr_cnt_reg <= 12'h000;
         cpu_seen_reg <= 1'b0;
         tmr_seen_reg <= 1'b0;
      end else begin
         cpu_cnt_reg <= $changed(CPU_CLK) ? 12'h000 : cpu_cnt_reg + 12'h001;
         tmr_cnt_reg <= $changed(TIMER_CLK) ? 12'h000 : tmr_cnt_reg + 12'h001;
         cpu_seen_reg <= cpu_seen_reg | $changed(CPU_CLK);
         tmr_seen_reg <= tmr_seen_reg | $changed(TIMER_CLK);
      end
   end
   AST_CPU_HALF: assert property (cpu_seen_reg && $changed(CPU_CLK) |-> cpu_cnt_reg == 12'h013)
      else $error("cpu clock half period wrong");
   AST_TMR_HALF: assert property (tmr_seen_reg && $changed(TIMER_CLK) |-> tmr_cnt_reg == 12'h9ff)
      else $error("timer clock half period wrong");
   // channel b carries the same wave as a in the bench, so either may gate
   AST_GATE_EDGE: assert property ($changed(GATE_LED) |-> CHA_P && !$past(CHA_P, 8))
      else $error("gate moved away from a measured edge");
   AST_IRQ_END: assert property ($fell(GATE_LED) |-> ##[0:3] !IRQ_N)
      else $error("no interrupt after gate closed");
   AST_IRQ_HOLD: assert property ((!DATA_STROBE)[*8] ##0 !IRQ_N |=> !IRQ_N)
      else $error("interrupt dropped without a read");
   AST_HELD: assert property (!IRQ_N |-> !GATE_LED)
      else $error("gate reopened over pending results");
   AST_OE_DATA: assert property (BUS_OE |-> $past(DATA_STROBE, 3)
      && $past(READ_NOT_WRITE, 3) && !$past(COUNTER_CHIP_SELECT_N, 3))
      else $error("bus driven outside a selected read");
   AST_EXT_FLAG: assert property ((!RST && $stable(EXT_LEVEL))[*4] |-> EXT_PRESENT == EXT_LEVEL)
      else $error("presence flag does not follow level");
   AST_FC_STATIC: assert property ((!DATA_STROBE && $stable(CHA_P)
      && $stable(CHB_P))[*8] |-> $stable(FUNCTION_CODE))
      else $error("function code moved with quiet inputs");
endmodule // rmc_properties
`default_nettype wire

/* File: verification/rmc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// processor model on the multiplexed bus
// --------------------------------------------
module rmc_host (
   // clock
   input wire logic clk,
   // bus level on the wire
   input wire logic [7:0] bus_in,
   // strobes and drive
   output logic adr_stb,
   output logic dat_stb,
   output logic rnw,
   output logic cs_n,
   output logic [7:0] bus_o
);
   // idle bus: no strobes, chip deselected
   initial begin
      adr_stb = 1'b0;
      dat_stb = 1'b0;
      rnw = 1'b1;
      cs_n = 1'b1;
      bus_o = 8'h00;
   end
   // one bus cycle; phases held six clocks so the core's synchronisers see each
   task automatic acc(input logic wr, input logic [5:0] adr, input logic [7:0] wd,
      output logic [7:0] rd);
      @(posedge clk);
      adr_stb <= 1'b1;
      bus_o <= {2'h0, adr};
      repeat (6) @(posedge clk);
      adr_stb <= 1'b0;
      repeat (6) @(posedge clk);
      dat_stb <= 1'b1;
      rnw <= ~wr;
      cs_n <= 1'b0;
      bus_o <= wr ? wd : ~bus_o; // released on a read: inverse of last level
      repeat (6) @(posedge clk);
      rd = bus_in;
      dat_stb <= 1'b0;
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      rnw <= 1'b1;
      bus_o <= ~bus_o;
      repeat (2) @(posedge clk);
   endtask
endmodule // rmc_host
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.vh"
// --------------------------------------------
// bench for the measurement core
// --------------------------------------------
module testbench;
   logic sys_clk, rst, cha, int_ref, ext_ref, ext_level, sel_n;
   logic adr_stb, dat_stb, rnw, cs_n, bus_oe, irq_n, ext_present, gate_led;
   logic std_out, ref_out, cpu_clk, timer_clk;
   logic [7:0] host_bus, bus_out, bus_wire, rd_b;
   logic [4:0] fcode;
   logic [4:0] codes [9] = '{`RMC_FC_FIRST_CHANNEL_FREQUENCY, `RMC_FC_SECOND_CHANNEL_FREQUENCY, `RMC_FC_PERIOD_A, `RMC_FC_TI_AB,
      `RMC_FC_TOTAL_A_BY_B, `RMC_FC_RATIO_AB, `RMC_FC_CHECK, `RMC_FC_TOTAL_A, `RMC_FC_TIME};
   int failures, tests_run, cyc;
   // wire level: core drives while enabled, else the host's level
   assign bus_wire = bus_oe ? bus_out : host_bus;
   rmc_top rmc_top_i (.SYS_CLK(sys_clk), .RST(rst),
      .CHA_P(cha), .CHA_N(~cha), .CHB_P(cha), .CHB_N(~cha),
      .INT_REF(int_ref), .EXT_REF(ext_ref), .EXT_LEVEL(ext_level), .REF_SELECT_N(sel_n),
      .ADDR_STROBE(adr_stb), .DATA_STROBE(dat_stb), .READ_NOT_WRITE(rnw),
      .COUNTER_CHIP_SELECT_N(cs_n), .BUS_IN(bus_wire), .BUS_OUT(bus_out), .BUS_OE(bus_oe),
      .IRQ_N(irq_n), .EXT_PRESENT(ext_present), .GATE_LED(gate_led), .FUNCTION_CODE(fcode),
      .STD_OUT_10M(std_out), .REF_OUT_10M(ref_out), .CPU_CLK(cpu_clk), .TIMER_CLK(timer_clk));
   rmc_host host_i (.clk(sys_clk), .bus_in(bus_wire), .adr_stb(adr_stb), .dat_stb(dat_stb),
      .rnw(rnw), .cs_n(cs_n), .bus_o(host_bus));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // standards and channel from one count; offset keeps channel edges apart from the internal standard's so counts are exact
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc % 10 == 0) int_ref <= ~int_ref;
      if (cyc % 5 == 0) ext_ref <= ~ext_ref;
      if (cyc % 20 == 5) cha <= ~cha;
      if (cyc == 60000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (failures == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic rd32(input logic [5:0] base, output logic [31:0] v);
      for (int i = 0; i < 4; i++) begin
         host_i.acc(1'b0, base + 6'(i), 8'h00, rd_b);
         v[8*i +: 8] = rd_b;
      end
   endtask
   task automatic t_reset();
      chk("irq", irq_n, 1'b1);
      chk("code", fcode, `RMC_FC_FIRST_CHANNEL_FREQUENCY);
      host_i.acc(1'b0, `RMC_OFS_GTIME_HI, 8'h00, rd_b);
      chk("gtime hi", rd_b, 8'h01);
      host_i.acc(1'b0, 6'h3f, 8'h00, rd_b);
      chk("unmapped", rd_b, 8'h00);
   endtask
   // every function: its code checked on the pins, the function read back over the bus
   task automatic t_codes();
      for (int f = 0; f < 9; f++) begin
         host_i.acc(1'b1, `RMC_OFS_FUNC, 8'(f), rd_b);
         chk("code", fcode, codes[f]);
         host_i.acc(1'b0, `RMC_OFS_FUNC, 8'h00, rd_b);
         chk("func", rd_b, 8'(f));
      end
   endtask
   // one gate of 256 reference pulses: 128 channel cycles at two pulses each
   task automatic t_measure(input logic [3:0] fn, input logic sf21);
      logic [31:0] g, e;
      int n;
      host_i.acc(1'b1, `RMC_OFS_FUNC, {4'h0, fn}, rd_b);
      host_i.acc(1'b1, `RMC_OFS_GTIME_LO, 8'h01, rd_b);
      host_i.acc(1'b1, `RMC_OFS_GTIME_HI, 8'h00, rd_b);
      host_i.acc(1'b1, `RMC_OFS_CTRL, {6'h00, sf21, 1'b1}, rd_b);
      n = 0;
      while (irq_n !== 1'b0 && n < 20000) begin
         @(posedge sys_clk);
         n++;
         if (n == 3000) begin
            chk("gate", gate_led, 1'b1);
            if (fn == `RMC_FN_CHECK) chk("line3", fcode[3], 1'b1);
         end
      end
      chk("irq", irq_n, 1'b0);
      if (fn == `RMC_FN_CHECK) chk("line3", fcode[3], 1'b0);
      host_i.acc(1'b1, `RMC_OFS_CTRL, 8'h01, rd_b);
      rd32(`RMC_OFS_GATE_CNT0, g);
      rd32(`RMC_OFS_EVT_CNT0, e);
      chk("gate cnt", g, 32'h00000100);
      chk("events", e, 32'h00000080);
      host_i.acc(1'b0, `RMC_OFS_STATUS, 8'h00, rd_b);
      chk("status", rd_b[3:0], 4'h1);
      repeat (8) @(posedge sys_clk);
      chk("irq clr", irq_n, 1'b1);
   endtask
   // timebase choice: external runs twice as fast, so edge counts tell which one is used
   task automatic t_ref(input logic lvl, input logic sn, input logic use_ext);
      int s, r;
      logic ps, pr;
      ext_level <= lvl;
      sel_n <= sn;
      repeat (10) @(posedge sys_clk);
      s = 0;
      r = 0;
      repeat (200) begin
         ps = std_out;
         pr = ref_out;
         @(posedge sys_clk);
         s += int'(std_out !== ps);
         r += int'(ref_out !== pr);
      end
      chk("std src", s > 30, use_ext);
      chk("ref int", r > 15 && r < 25, 1'b1);
      chk("present", ext_present, lvl);
      host_i.acc(1'b0, `RMC_OFS_STATUS, 8'h00, rd_b);
      chk("ext flags", rd_b[2:1], {use_ext, lvl});
   endtask
   initial begin
      rst = 1'b1;
      cyc = 0;
      int_ref = 1'b0;
      ext_ref = 1'b0;
      cha = 1'b0;
      ext_level = 1'b0;
      sel_n = 1'b1;
      failures = 0;
      tests_run = 0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_codes();
      t_measure(`RMC_FN_FIRST_CHANNEL_FREQUENCY, 1'b0);
      t_measure(`RMC_FN_CHECK, 1'b0);
      t_measure(`RMC_FN_SECOND_CHANNEL_FREQUENCY, 1'b1);
      t_ref(1'b0, 1'b0, 1'b0);
      t_ref(1'b1, 1'b1, 1'b0);
      t_ref(1'b1, 1'b0, 1'b1);
      wrap_up();
   end
endmodule // testbench
bind rmc_top rmc_properties rmc_properties_i (.SYS_CLK, .RST, .CHA_P, .CHB_P, .EXT_LEVEL,
   .DATA_STROBE, .READ_NOT_WRITE, .COUNTER_CHIP_SELECT_N, .BUS_OE, .IRQ_N, .EXT_PRESENT,
   .GATE_LED, .FUNCTION_CODE, .CPU_CLK, .TIMER_CLK);
`default_nettype wire
